// *** shared/tpc_pkg.sv ***
// Constants for the timer compare and PWM channel block
package tpc_pkg;
	// ==========================================================
	// Sizes
	localparam int NCH = 2;
	localparam int AW = 8;
	// ==========================================================
	// Register byte addresses (one byte per 32-bit word)
	localparam logic [7:0] OFS_SC = 8'h00;
	localparam logic [7:0] OFS_CNTH = 8'h04;
	localparam logic [7:0] OFS_CNTL = 8'h08;
	localparam logic [7:0] OFS_MODH = 8'h0C;
	localparam logic [7:0] OFS_MODL = 8'h10;
	localparam logic [7:0] OFS_CH_BASE = 8'h14;
	localparam logic [7:0] CH_STRIDE = 8'h0C;
	localparam logic [7:0] CH_SC = 8'h00;
	localparam logic [7:0] CH_VH = 8'h04;
	localparam logic [7:0] CH_VL = 8'h08;
	// ==========================================================
	// Timer status/control fields
	localparam int SC_TOF = 7;
	localparam int SC_OVERFLOW_IRQ_ENABLE = 6;
	localparam int SC_CENTER_ALIGN_SELECT = 5;
	localparam int SC_CLKS_HI = 4;
	localparam int SC_CLKS_LO = 3;
	localparam int SC_PS_HI = 2;
	localparam int SC_PS_LO = 0;
	localparam int SC_CFG_HI = 6;
	// ==========================================================
	// Channel status/control fields
	localparam int CSC_CHF = 7;
	localparam int CSC_CHIE = 6;
	localparam int CSC_MSB = 5;
	localparam int CSC_MSA = 4;
	localparam int CSC_ELSB = 3;
	localparam int CSC_ELSA = 2;
	// ==========================================================
	// Encodings and values
	localparam logic [1:0] CLKS_OFF = 2'h0;
	localparam logic [1:0] CLKS_BUS = 2'h1;
	localparam logic [1:0] CLKS_FIXED = 2'h2;
	localparam logic [1:0] CLKS_EXT = 2'h3;
	localparam logic [1:0] ELS_TOGGLE = 2'h1;
	localparam logic [1:0] ELS_CLEAR = 2'h2;
	localparam logic [1:0] ELS_SET = 2'h3;
	localparam logic [1:0] ELS_NONE = 2'h0;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [7:0] REG_RST = 8'h00;
endpackage

// *** hw/tpc_timer_pwm_unit.sv ***
// Timer counter with output compare, edge and center PWM channels
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_pwm_unit (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [tpc_pkg::AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// Counter clock sources
	input wire logic i_fixed_tick,
	input wire logic i_ext_clk,
	// Channel pins
	input wire logic [tpc_pkg::NCH-1:0] i_chan_in,
	output logic [tpc_pkg::NCH-1:0] o_chan_out,
	output logic [tpc_pkg::NCH-1:0] o_chan_oe,
	// Interrupt requests
	output logic o_ovf_irq,
	output logic [tpc_pkg::NCH-1:0] o_chan_irq
);
	import tpc_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] sc;
		logic tof_arm;
		logic [15:0] cnt;
		logic down;
		logic [6:0] pre;
		logic [15:0] mod;
		logic [7:0] modb_h;
		logic [7:0] modb_l;
		logic mod_gh;
		logic mod_gl;
		logic [7:0] lat;
		logic lat_v;
		logic lat_hi;
		logic [NCH-1:0][7:0] csc;
		logic [NCH-1:0] chf_arm;
		logic [NCH-1:0][15:0] cv;
		logic [NCH-1:0][7:0] cvb_h;
		logic [NCH-1:0][7:0] cvb_l;
		logic [NCH-1:0] cv_gh;
		logic [NCH-1:0] cv_gl;
		logic [NCH-1:0] out;
		logic [NCH-1:0] oe;
		logic [NCH-1:0] in_prev;
		logic ext_prev;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic ovf_irq;
		logic [NCH-1:0] ch_irq;
	} tpc_state_t;

	tpc_state_t s_ff;
	tpc_state_t nxt_s;

	// ==========================================================
	// Counter clocking
	logic [1:0] clks;
	logic [2:0] ps;
	logic center_align_select;
	logic src_evt;
	logic [7:0] pre_sh;
	logic [6:0] pre_term;
	logic tick;
	logic [15:0] term;
	logic [15:0] cnt_inc;
	logic [15:0] cnt_dec;
	logic [15:0] cnt_nx;
	logic wrap_up;
	logic turn_top;
	logic turn_bot;
	logic step_up;
	logic tof_evt;
	logic reload_pt;

	assign clks = s_ff.sc[SC_CLKS_HI:SC_CLKS_LO];
	assign ps = s_ff.sc[SC_PS_HI:SC_PS_LO];
	assign center_align_select = s_ff.sc[SC_CENTER_ALIGN_SELECT];

	always_comb begin
		case (clks)
			CLKS_BUS: src_evt = 1'b1;
			CLKS_FIXED: src_evt = i_fixed_tick;
			CLKS_EXT: src_evt = i_ext_clk & ~s_ff.ext_prev;
			default: src_evt = 1'b0;
		endcase
	end

	// Prescaler divides by two to the power ps
	assign pre_sh = 8'h01 << ps;
	assign pre_term = pre_sh[6:0] - 7'h01;
	assign tick = src_evt && (s_ff.pre == pre_term);
	assign term = (s_ff.mod == CNT_ZERO) ? CNT_MAX : s_ff.mod;
	assign cnt_inc = s_ff.cnt + CNT_ONE;
	assign cnt_dec = s_ff.cnt - CNT_ONE;
	assign wrap_up = tick && !center_align_select && (s_ff.cnt == term);
	assign turn_top = tick && center_align_select && !s_ff.down && (s_ff.cnt == term);
	assign turn_bot = tick && center_align_select && s_ff.down && (s_ff.cnt == CNT_ZERO);
	assign tof_evt = wrap_up | turn_top;
	assign step_up = !(turn_top || (center_align_select && s_ff.down && !turn_bot));
	// Reload point: stepping up from terminal minus one
	assign reload_pt = tick && !s_ff.down && (cnt_inc == term)
		&& !turn_top;

	always_comb begin
		if (wrap_up) begin
			cnt_nx = CNT_ZERO;
		end else if (turn_top) begin
			cnt_nx = cnt_dec;
		end else if (turn_bot) begin
			cnt_nx = cnt_inc;
		end else if (center_align_select && s_ff.down) begin
			cnt_nx = cnt_dec;
		end else begin
			cnt_nx = cnt_inc;
		end
	end

	// ==========================================================
	// APB decode
	logic acc;
	logic done;
	logic wr_done;
	logic sel_sc;
	logic sel_cnth;
	logic sel_cntl;
	logic sel_modh;
	logic sel_modl;
	logic [NCH-1:0] sel_csc;
	logic [NCH-1:0] sel_cvh;
	logic [NCH-1:0] sel_cvl;
	logic any_sel;
	logic [7:0] rd_byte;

	assign acc = i_psel && i_penable && !s_ff.pready;
	assign done = i_psel && i_penable && s_ff.pready;
	assign wr_done = done && i_pwrite;
	assign sel_sc = (i_paddr == OFS_SC);
	assign sel_cnth = (i_paddr == OFS_CNTH);
	assign sel_cntl = (i_paddr == OFS_CNTL);
	assign sel_modh = (i_paddr == OFS_MODH);
	assign sel_modl = (i_paddr == OFS_MODL);
	assign any_sel = sel_sc | sel_cnth | sel_cntl | sel_modh | sel_modl
		| (|sel_csc) | (|sel_cvh) | (|sel_cvl);

	// ==========================================================
	// Per channel mode decode and events
	logic [NCH-1:0][1:0] els;
	logic [NCH-1:0] elsa;
	logic [NCH-1:0] ic;
	logic [NCH-1:0] oc;
	logic [NCH-1:0] epwm;
	logic [NCH-1:0] cpwm;
	logic [NCH-1:0] match;
	logic [NCH-1:0] cap;
	logic [NCH-1:0] rise;
	logic [NCH-1:0] fall;

	for (genvar g = 0; g < NCH; g++) begin : g_ch
		localparam logic [7:0] BASE = 8'(OFS_CH_BASE + g * CH_STRIDE);
		assign sel_csc[g] = (i_paddr == BASE + CH_SC);
		assign sel_cvh[g] = (i_paddr == BASE + CH_VH);
		assign sel_cvl[g] = (i_paddr == BASE + CH_VL);
		assign els[g] = s_ff.csc[g][CSC_ELSB:CSC_ELSA];
		assign elsa[g] = s_ff.csc[g][CSC_ELSA];
		assign ic[g] = !center_align_select && !s_ff.csc[g][CSC_MSB]
			&& !s_ff.csc[g][CSC_MSA];
		assign oc[g] = !center_align_select && !s_ff.csc[g][CSC_MSB]
			&& s_ff.csc[g][CSC_MSA];
		assign epwm[g] = !center_align_select && s_ff.csc[g][CSC_MSB];
		assign cpwm[g] = center_align_select && (els[g] != ELS_NONE);
		// Compare only on counter ticks, against the new count
		assign match[g] = tick && (cnt_nx == s_ff.cv[g])
			&& (oc[g] | epwm[g] | cpwm[g]);
		assign rise[g] = i_chan_in[g] & ~s_ff.in_prev[g];
		assign fall[g] = ~i_chan_in[g] & s_ff.in_prev[g];
		assign cap[g] = ic[g] && ((els[g] == ELS_TOGGLE && rise[g])
			|| (els[g] == ELS_CLEAR && fall[g])
			|| (els[g] == ELS_SET && (rise[g] | fall[g])));
	end

	// ==========================================================
	// Read data mux
	always_comb begin
		rd_byte = REG_RST;
		if (sel_sc) begin
			rd_byte = s_ff.sc;
		end
		if (sel_cnth) begin
			rd_byte = (s_ff.lat_v && s_ff.lat_hi) ? s_ff.lat : s_ff.cnt[15:8];
		end
		if (sel_cntl) begin
			rd_byte = (s_ff.lat_v && !s_ff.lat_hi) ? s_ff.lat : s_ff.cnt[7:0];
		end
		if (sel_modh) begin
			rd_byte = s_ff.mod[15:8];
		end
		if (sel_modl) begin
			rd_byte = s_ff.mod[7:0];
		end
		for (int c = 0; c < NCH; c++) begin
			if (sel_csc[c]) begin
				rd_byte = s_ff.csc[c];
			end
			if (sel_cvh[c]) begin
				rd_byte = s_ff.cv[c][15:8];
			end
			if (sel_cvl[c]) begin
				rd_byte = s_ff.cv[c][7:0];
			end
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		nxt_s = s_ff;
		nxt_s.ext_prev = i_ext_clk;
		nxt_s.in_prev = i_chan_in;
		nxt_s.pready = 1'b0;
		nxt_s.pslverr = 1'b0;
		// Counter advance
		if (tick) begin
			nxt_s.pre = '0;
			nxt_s.cnt = cnt_nx;
			if (turn_top) begin
				nxt_s.down = 1'b1;
			end
			if (turn_bot) begin
				nxt_s.down = 1'b0;
			end
		end else if (src_evt) begin
			nxt_s.pre = s_ff.pre + 7'h01;
		end
		if (!center_align_select) begin
			nxt_s.down = 1'b0;
		end
		// Channel pin actions
		for (int c = 0; c < NCH; c++) begin
			if (match[c] && oc[c]) begin
				case (els[c])
					ELS_TOGGLE: nxt_s.out[c] = ~s_ff.out[c];
					ELS_CLEAR: nxt_s.out[c] = 1'b0;
					ELS_SET: nxt_s.out[c] = 1'b1;
					default: nxt_s.out[c] = s_ff.out[c];
				endcase
			end
			if (tick && epwm[c]) begin
				// Match wins over overflow so zero gives 0%
				if (match[c]) begin
					nxt_s.out[c] = elsa[c];
				end else if (cnt_nx == CNT_ZERO) begin
					nxt_s.out[c] = ~elsa[c];
				end
			end
			if (tick && cpwm[c]) begin
				if (s_ff.cv[c] == CNT_ZERO || s_ff.cv[c][15]) begin
					nxt_s.out[c] = elsa[c];
				end else if (s_ff.cv[c] > s_ff.mod && s_ff.mod != CNT_ZERO) begin
					nxt_s.out[c] = ~elsa[c];
				end else if (match[c]) begin
					nxt_s.out[c] = step_up ? elsa[c] : ~elsa[c];
				end
			end
			if (cap[c]) begin
				nxt_s.cv[c] = s_ff.cnt;
			end
			// Pin released to general purpose I/O in capture
			nxt_s.oe[c] = (els[c] != ELS_NONE) && !ic[c];
		end
		// APB access phase: answer one cycle later
		if (acc) begin
			nxt_s.pready = 1'b1;
			nxt_s.pslverr = ~any_sel;
			nxt_s.prdata = {24'h000000, rd_byte};
			if (!i_pwrite) begin
				if (sel_sc && s_ff.sc[SC_TOF]) begin
					nxt_s.tof_arm = 1'b1;
				end
				// Reading one counter byte freezes the other
				if (sel_cnth || sel_cntl) begin
					if (s_ff.lat_v && (s_ff.lat_hi == sel_cnth)) begin
						nxt_s.lat_v = 1'b0;
					end else begin
						nxt_s.lat_v = 1'b1;
						nxt_s.lat_hi = sel_cntl;
						nxt_s.lat = sel_cntl ? s_ff.cnt[15:8] : s_ff.cnt[7:0];
					end
				end
				for (int c = 0; c < NCH; c++) begin
					if (sel_csc[c] && s_ff.csc[c][CSC_CHF]) begin
						nxt_s.chf_arm[c] = 1'b1;
					end
				end
			end
		end
		// Writes take effect at the completing edge
		if (wr_done) begin
			if (sel_sc) begin
				nxt_s.sc[SC_CFG_HI:0] = i_pwdata[SC_CFG_HI:0];
				if (!i_pwdata[SC_TOF] && s_ff.tof_arm) begin
					nxt_s.sc[SC_TOF] = 1'b0;
				end
				nxt_s.tof_arm = 1'b0;
				nxt_s.mod_gh = 1'b0;
				nxt_s.mod_gl = 1'b0;
			end
			if (sel_cnth || sel_cntl) begin
				nxt_s.cnt = CNT_ZERO;
				nxt_s.pre = '0;
				nxt_s.down = 1'b0;
				nxt_s.lat_v = 1'b0;
			end
			if (sel_modh) begin
				nxt_s.modb_h = i_pwdata[7:0];
				nxt_s.mod_gh = 1'b1;
			end
			if (sel_modl) begin
				nxt_s.modb_l = i_pwdata[7:0];
				nxt_s.mod_gl = 1'b1;
			end
			for (int c = 0; c < NCH; c++) begin
				if (sel_csc[c]) begin
					nxt_s.csc[c][CSC_CHIE:CSC_ELSA] = i_pwdata[CSC_CHIE:CSC_ELSA];
					if (!i_pwdata[CSC_CHF] && s_ff.chf_arm[c]) begin
						nxt_s.csc[c][CSC_CHF] = 1'b0;
					end
					nxt_s.chf_arm[c] = 1'b0;
					nxt_s.cv_gh[c] = 1'b0;
					nxt_s.cv_gl[c] = 1'b0;
				end
				// Capture values are read only
				if (sel_cvh[c] && !ic[c]) begin
					nxt_s.cvb_h[c] = i_pwdata[7:0];
					nxt_s.cv_gh[c] = 1'b1;
				end
				if (sel_cvl[c] && !ic[c]) begin
					nxt_s.cvb_l[c] = i_pwdata[7:0];
					nxt_s.cv_gl[c] = 1'b1;
				end
			end
		end
		// Buffered loads; clock off loads at the second byte
		if (nxt_s.mod_gh && nxt_s.mod_gl && (clks == CLKS_OFF || reload_pt)) begin
			nxt_s.mod = {nxt_s.modb_h, nxt_s.modb_l};
			nxt_s.mod_gh = 1'b0;
			nxt_s.mod_gl = 1'b0;
		end
		for (int c = 0; c < NCH; c++) begin
			if (nxt_s.cv_gh[c] && nxt_s.cv_gl[c] && !ic[c]
				&& (clks == CLKS_OFF || (oc[c] ? tick : reload_pt))) begin
				nxt_s.cv[c] = {nxt_s.cvb_h[c], nxt_s.cvb_l[c]};
				nxt_s.cv_gh[c] = 1'b0;
				nxt_s.cv_gl[c] = 1'b0;
			end
			// Event beats a clear in the same cycle
			if (match[c] || cap[c]) begin
				nxt_s.csc[c][CSC_CHF] = 1'b1;
				nxt_s.chf_arm[c] = 1'b0;
			end
			nxt_s.ch_irq[c] = nxt_s.csc[c][CSC_CHF] && nxt_s.csc[c][CSC_CHIE];
		end
		if (tof_evt) begin
			nxt_s.sc[SC_TOF] = 1'b1;
			nxt_s.tof_arm = 1'b0;
		end
		nxt_s.ovf_irq = nxt_s.sc[SC_TOF] && nxt_s.sc[SC_OVERFLOW_IRQ_ENABLE];
	end

	// Reset clears all control: clock off, channels in capture
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_pready = s_ff.pready;
	assign o_prdata = s_ff.prdata;
	assign o_pslverr = s_ff.pslverr;
	assign o_chan_out = s_ff.out;
	assign o_chan_oe = s_ff.oe;
	assign o_ovf_irq = s_ff.ovf_irq;
	assign o_chan_irq = s_ff.ch_irq;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	logic cnt_wr;
	assign cnt_wr = wr_done && (sel_cnth || sel_cntl);

	sequence s_cnt_write;
		wr_done && (sel_cnth || sel_cntl);
	endsequence

	sequence s_turn_top;
		turn_top && !cnt_wr;
	endsequence

	tof_wrap_a: assert property (wrap_up && !cnt_wr |=>
		s_ff.sc[SC_TOF] && s_ff.cnt == CNT_ZERO)
		else $error("overflow did not wrap and flag");
	cpwm_top_a: assert property (s_turn_top |=>
		s_ff.down && s_ff.cnt == 16'($past(s_ff.cnt) - CNT_ONE))
		else $error("center count did not turn down");
	cpwm_bot_a: assert property (turn_bot && !cnt_wr |=>
		!s_ff.down && s_ff.cnt == CNT_ONE)
		else $error("center count did not turn up");
	irq_level_a: assert property (
		o_ovf_irq == (s_ff.sc[SC_TOF] && s_ff.sc[SC_OVERFLOW_IRQ_ENABLE]))
		else $error("overflow irq not flag and enable");
	clear_keep_a: assert property (tof_evt && wr_done && sel_sc
		&& !i_pwdata[SC_TOF] |=> s_ff.sc[SC_TOF] && !s_ff.tof_arm)
		else $error("overflow event lost to clear");
	clk_off_a: assert property (clks == CLKS_OFF |-> !tick)
		else $error("counter ticked with clock off");
	cnt_reset_a: assert property (s_cnt_write |=>
		s_ff.cnt == CNT_ZERO && !s_ff.lat_v ##1 s_ff.cnt <= CNT_ONE)
		else $error("counter write did not clear");
	sc_drop_a: assert property (wr_done && sel_sc |=>
		!s_ff.mod_gh && !s_ff.mod_gl)
		else $error("modulo bytes kept after control write");
	for (genvar g = 0; g < NCH; g++) begin : g_chk
		chf_match_a: assert property (match[g] |=>
			s_ff.csc[g][CSC_CHF])
			else $error("channel flag not set on match");
		epwm_low_a: assert property (match[g] && epwm[g] && !elsa[g]
			|=> !o_chan_out[g])
			else $error("edge PWM not low at match");
		oc_toggle_a: assert property (match[g] && oc[g]
			&& els[g] == ELS_TOGGLE |=> o_chan_out[g] != $past(o_chan_out[g]))
			else $error("compare toggle missed");
		csc_drop_a: assert property (wr_done && sel_csc[g] |=>
			!s_ff.cv_gh[g] && !s_ff.cv_gl[g])
			else $error("channel bytes kept after control write");
	end
endmodule
`default_nettype wire

// *** testbench/tpc_pin_partner.sv ***
// Model of the circuits that sit on the channel pins
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_partner (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// Channel pins
	input wire logic [tpc_pkg::NCH-1:0] i_chan_out,
	input wire logic [tpc_pkg::NCH-1:0] i_chan_oe,
	output logic [tpc_pkg::NCH-1:0] o_pin_lvl,
	// External counter source
	output logic o_ext_clk
);
	import tpc_pkg::*;
	logic [NCH-1:0] float_ff;
	logic [1:0] div_ff;
	// ==========================================================
	// Pin levels and external source
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			float_ff <= '0;
			div_ff <= 2'h0;
		end else begin
			float_ff <= ~float_ff;
			div_ff <= div_ff + 2'h1;
		end
	end
	// No pull on a released pin: a moving pattern, never a stale level
	assign o_pin_lvl = (i_chan_oe & i_chan_out) | (~i_chan_oe & float_ff);
	// Quarter of the bus rate, the fastest source allowed
	assign o_ext_clk = div_ff[1];
endmodule
`default_nettype wire

// *** testbench/test_tpc_timer_pwm_unit.sv ***
// Register-level testbench of the timer compare and PWM block
`timescale 1ns/1ps
`default_nettype none
module test_tpc_timer_pwm_unit;
	import tpc_pkg::*;
	localparam logic [7:0] CSC0 = OFS_CH_BASE + CH_SC;
	localparam logic [7:0] VH0 = OFS_CH_BASE + CH_VH;
	localparam logic [7:0] VL0 = OFS_CH_BASE + CH_VL;
	localparam logic [7:0] CSC1 = OFS_CH_BASE + CH_STRIDE;
	logic core_clk, arst_n, psel, penable, pwrite, fixed_tick, ext_clk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic pready, pslverr, erv, ovf_irq;
	logic [NCH-1:0] pin_lvl, chan_out, chan_oe, chan_irq;
	logic [1:0] tdiv;
	int error_cnt, compares, hi, rs;
	logic [7:0] rst_addrs[9];
	logic [7:0] scs[5];
	int his[5], rss[5];
	tpc_timer_pwm_unit u_tpc_timer_pwm_unit (.i_core_clk(core_clk),
		.i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
		.i_fixed_tick(fixed_tick), .i_ext_clk(ext_clk),
		.i_chan_in(pin_lvl), .o_chan_out(chan_out), .o_chan_oe(chan_oe),
		.o_ovf_irq(ovf_irq), .o_chan_irq(chan_irq));
	tpc_pin_partner u_tpc_pin_partner (.i_core_clk(core_clk),
		.i_arst_n(arst_n), .i_chan_out(chan_out), .i_chan_oe(chan_oe),
		.o_pin_lvl(pin_lvl), .o_ext_clk(ext_clk));
	// ==========================================================
	// Clock and fixed-rate tick, one pulse every four cycles
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		tdiv <= tdiv + 2'h1;
		fixed_tick <= (tdiv == 2'h3);
	end
	// ==========================================================
	// Checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (error_cnt == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================================
	// APB master: one idle cycle between transfers
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(negedge core_clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			error_cnt++;
			report_and_stop();
		end
		rdv = prdata;
		erv = pslverr;
		@(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m);
		apb(1'b0, a, 8'h00);
		check(rdv & {24'h000000, m}, {24'h000000, e & m});
	endtask
	// ==========================================================
	// Pin waveform: high cycles and rising edges over n cycles
	task automatic window(input int n, output int h, output int r);
		logic prev;
		@(negedge core_clk);
		prev = chan_out[0];
		h = 0;
		r = 0;
		repeat (n) begin
			@(negedge core_clk);
			h += (chan_out[0] === 1'b1);
			r += (chan_out[0] === 1'b1 && prev === 1'b0);
			prev = chan_out[0];
		end
	endtask
	// Values load at once while the clock is off, then the clock starts
	task automatic pwm_case(input logic [7:0] sc, input logic [7:0] csc,
		input logic [15:0] md, input logic [15:0] v, input int n,
		input int eh, input int er);
		wr(OFS_SC, sc & 8'hE7);
		wr(OFS_MODH, md[15:8]);
		wr(OFS_MODL, md[7:0]);
		wr(CSC0, csc);
		wr(VH0, v[15:8]);
		wr(VL0, v[7:0]);
		wr(OFS_CNTH, 8'h00);
		wr(OFS_SC, sc);
		repeat (50) @(posedge core_clk);
		window(n, hi, rs);
		if (eh >= 0)
			check(hi, eh);
		check(rs, er);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		fixed_tick = 1'b0;
		tdiv = 2'h0;
		error_cnt = 0;
		compares = 0;
		rst_addrs = '{OFS_SC, OFS_CNTH, OFS_CNTL, OFS_MODH, OFS_MODL,
			CSC0, VH0, VL0, CSC1};
		scs = '{8'h08, 8'h10, 8'h18, 8'h0A, 8'h00};
		his = '{32, 32, 32, 32, -1};
		rss = '{8, 2, 2, 2, 0};
		repeat (16) @(posedge core_clk);
		check({chan_out, chan_oe, ovf_irq, chan_irq}, 32'h0);
		arst_n <= 1'b1;
		foreach (rst_addrs[k])
			rd_chk(rst_addrs[k], 8'h00, 8'hFF);
		apb(1'b0, 8'hFC, 8'h00);
		check({31'h0, erv}, 32'h1);
		check(rdv, 32'h0);
		wr(8'hFC, 8'hFF);
		check(erv, 1'b1);
		pwm_case(8'h48, 8'h28, 16'h0009, 16'h0004, 40, 16, 4);
		check(chan_oe[0], 1'b1);
		check(ovf_irq, 1'b1);
		// Stop the counter first so no new overflow lands between the steps
		wr(OFS_SC, 8'h40);
		rd_chk(OFS_SC, 8'h80, 8'h80);
		wr(OFS_SC, 8'h40);
		@(negedge core_clk);
		check(ovf_irq, 1'b0);
		pwm_case(8'h08, 8'h24, 16'h0009, 16'h0004, 40, 24, 4);
		wr(VH0, 8'h00);
		wr(VL0, 8'h07);
		repeat (30) @(posedge core_clk);
		window(40, hi, rs);
		check(hi, 12);
		pwm_case(8'h08, 8'h28, 16'h0009, 16'h0000, 40, 0, 0);
		pwm_case(8'h08, 8'h28, 16'h0009, 16'h000A, 40, 40, 0);
		foreach (scs[k])
			pwm_case(scs[k], 8'h28, 16'h0009, 16'h0004, 80, his[k], rss[k]);
		// Only channel 0 active, so the center select covers all of them
		pwm_case(8'h28, 8'h08, 16'h0008, 16'h0003, 64, 24, 4);
		pwm_case(8'h28, 8'h08, 16'h0008, 16'h8003, 64, 0, 0);
		pwm_case(8'h28, 8'h08, 16'h0008, 16'h0009, 64, 64, 0);
		pwm_case(8'h08, 8'h5C, 16'h0009, 16'h0005, 40, 40, 0);
		check(chan_irq[0], 1'b1);
		pwm_case(8'h08, 8'h58, 16'h0009, 16'h0005, 40, 0, 0);
		pwm_case(8'h08, 8'h54, 16'h0009, 16'h0005, 40, 20, 2);
		wr(OFS_SC, 8'h00);
		wr(CSC0, 8'h5C);
		rd_chk(CSC0, 8'h80, 8'h80);
		wr(CSC0, 8'h5C);
		@(negedge core_clk);
		check(chan_irq[0], 1'b0);
		rd_chk(CSC0, 8'h00, 8'h80);
		wr(VH0, 8'h00);
		wr(VL0, 8'h07);
		rd_chk(VL0, 8'h07, 8'hFF);
		wr(VH0, 8'h01);
		wr(CSC0, 8'h5C);
		wr(VL0, 8'h09);
		rd_chk(VH0, 8'h00, 8'hFF);
		rd_chk(VL0, 8'h07, 8'hFF);
		wr(OFS_MODH, 8'h12);
		wr(OFS_SC, 8'h00);
		wr(OFS_MODL, 8'h34);
		rd_chk(OFS_MODH, 8'h00, 8'hFF);
		rd_chk(OFS_MODL, 8'h09, 8'hFF);
		wr(OFS_SC, 8'h08);
		wr(OFS_SC, 8'h00);
		wr(OFS_CNTL, 8'h55);
		rd_chk(OFS_CNTH, 8'h00, 8'hFF);
		rd_chk(OFS_CNTL, 8'h00, 8'hFF);
		report_and_stop();
	end
endmodule
`default_nettype wire
